// file: bench/rxr_host_model.sv
/*
 Host software model: loads configuration words and acknowledges interrupts.
 Assumes the same clock as the block and the block's load port timing.
*/
`timescale 1ns/10ps
module rxr_host_model
(
  input wire logic i_clk,
  input wire logic i_irq,
  output logic o_cfg_wr,
  output logic [1:0] o_cfg_sel,
  output logic [31:0] o_cfg_data,
  output logic o_irq_ack
);
  initial
  begin
    o_cfg_wr = 1'b0;
    o_cfg_sel = 2'h0;
    o_cfg_data = 32'h0000_0000;
    o_irq_ack = 1'b0;
  end

  // one word per call, held for a single edge
  task automatic load(input logic [1:0] sel, input logic [31:0] data);
    @(posedge i_clk);
    #1;
    o_cfg_wr = 1'b1;
    o_cfg_sel = sel;
    o_cfg_data = (sel == 2'h0) ? data : {16'h0000, 12'h000, data[3:0]};
    @(posedge i_clk);
    #1;
    o_cfg_wr = 1'b0;
  endtask

  // software answers a raised request one cycle later
  always @(posedge i_clk)
  begin
    #1;
    o_irq_ack = i_irq & ~o_irq_ack;
  end
endmodule // rxr_host_model

// file: bench/rxr_retain_test.sv
/*
 Self-checking bench for the receive fault retention block.
 Assumes the host model drives the config port and the interrupt acknowledge.
*/
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("Error t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module rxr_retain_test;
  import rxr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr, irq_ack, start, save, proto, multi, rx_byte, full, pool_e, fend, ab, crc;
  logic bus_err, iq_ovf, poll;
  logic [1:0] cfg_sel;
  logic [31:0] cfg_data, evt;
  logic [15:0] n201;
  logic byte_st, done, keep, skip, mark, ret, iq_wr, irq;
  logic [3:0] cause, err, dec;
  logic [15:0] len, pkeep, rkeep;
  logic [5:0] iq_code;
  logic [31:0] emask;
  int n_errors = 0;
  int tests_run = 0;
  int n_store = 0;
  int store_base = 0;

  always #10 clk = ~clk;

  // store strobes seen by the buffer side, counted per run
  always @(posedge clk)
    if (byte_st === 1'b1)
      n_store++;

  rxr_host_model i_rxr_host_model (.i_clk(clk), .i_irq(irq), .o_cfg_wr(cfg_wr), .o_cfg_sel(cfg_sel),
    .o_cfg_data(cfg_data), .o_irq_ack(irq_ack));

  rxr_retain i_rxr_retain (.I_MCLK(clk), .I_NRST(nrst), .I_CFG_WR(cfg_wr), .I_CFG_SEL(cfg_sel),
    .I_CFG_DATA(cfg_data), .I_FRM_START(start), .I_LINK_SAVE(save), .I_LINK_PROTO(proto),
    .I_MULTIBUF(multi), .I_N201(n201), .I_RX_BYTE(rx_byte), .I_FIFO_FULL(full), .I_POOL_EMPTY(pool_e),
    .I_FRM_END(fend), .I_ABORT(ab), .I_CRC_BAD(crc), .I_EVT(evt), .I_BUS_ERR(bus_err), .I_IQ_OVF(iq_ovf),
    .I_POLL_ONLY(poll), .I_IRQ_ACK(irq_ack), .O_BYTE_STORE(byte_st), .O_FRM_DONE(done), .O_KEEP(keep),
    .O_KEEP_CAUSE(cause), .O_ERR_CODE(err), .O_DATA_LEN(len), .O_SKIP_LAST_WORD(skip),
    .O_MARK_OVERSIZE(mark), .O_RETURN_BUFS(ret), .O_CNT_DEC(dec), .O_IQ_WR(iq_wr), .O_IQ_CODE(iq_code),
    .O_IRQ(irq), .O_EVT_MASK(emask), .O_PROTO_KEEP(pkeep), .O_RAW_KEEP(rkeep));

  ////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one frame; ff and pe are byte indexes of fifo full and pool empty
  task automatic frame(input logic s, p, m, input logic [15:0] n, input int nb, ff, pe, input logic a, c);
    int i;
    step();
    store_base = n_store;
    {start, save, proto, multi, n201} = {1'b1, s, p, m, n};
    step();
    start = 1'b0;
    for (i = 0; i < nb; i++)
    begin
      {rx_byte, full, pool_e} = {1'b1, i == ff, i >= pe};
      step();
    end
    {rx_byte, full, pool_e, fend, ab, crc} = {4'b0001, a, c};
    step();
    fend = 1'b0;
    for (i = 0; i < 4 && done !== 1'b1; i++)
      step();
    if (done !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
  endtask

  // outcome common to every frame; length only matters for kept frames
  task automatic chk(input logic [3:0] e, input logic k, input logic [3:0] d, input logic [15:0] l);
    `CHK(err, e)
    `CHK(keep, k)
    `CHK(dec, d)
    if (k)
      `CHK(len, l)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    i_rxr_host_model.load(2'h0, 32'hffff_ffff);
    `CHK(emask, 32'h6fff_7fff)
    i_rxr_host_model.load(2'h1, 32'h0000_ffff);
    i_rxr_host_model.load(2'h3, 32'h0000_1234);
    `CHK(pkeep, 16'h000f)
    `CHK(rkeep, 16'h0000)
    $display("test cfg done");
  endtask

  task automatic t_proto();
    i_rxr_host_model.load(2'h1, 32'h1);
    frame(1, 1, 0, 16'h00ff, 4, -1, 99, 0, 1);
    chk(4'h1, 1, 4'h0, 16'h0004);
    `CHK(cause, 4'h1)
    frame(0, 1, 0, 16'h00ff, 4, -1, 99, 0, 1);
    chk(4'h1, 0, 4'h1, 16'h0004);
    frame(1, 1, 0, 16'h00ff, 4, -1, 99, 1, 1);
    chk(4'h3, 1, 4'h0, 16'h0004);
    i_rxr_host_model.load(2'h1, 32'h2);
    frame(1, 1, 0, 16'h00ff, 4, -1, 99, 1, 0);
    chk(4'h2, 1, 4'h0, 16'h0004);
    `CHK(skip, 1'b1)
    i_rxr_host_model.load(2'h1, 32'h0);
    frame(1, 1, 0, 16'h00ff, 4, -1, 99, 1, 1);
    chk(4'h3, 0, 4'h3, 16'h0004);
    i_rxr_host_model.load(2'h1, 32'h6);
    frame(1, 1, 0, 16'h00ff, 4, 1, 99, 1, 0);
    chk(4'h6, 1, 4'h0, 16'h0001);
    `CHK(cause, 4'h4)
    $display("test proto done");
  endtask

  task automatic t_sizes();
    i_rxr_host_model.load(2'h1, 32'h8);
    frame(1, 1, 0, 16'h0005, 8, -1, 99, 0, 0);
    chk(4'h8, 1, 4'h0, 16'h0004);
    i_rxr_host_model.load(2'h1, 32'h4);
    frame(1, 1, 0, 16'h00ff, 6, 3, 99, 0, 0);
    chk(4'h4, 1, 4'h0, 16'h0003);
    $display("test sizes done");
  endtask

  task automatic t_raw();
    i_rxr_host_model.load(2'h2, 32'h8);
    i_rxr_host_model.load(2'h1, 32'h0);
    frame(1, 0, 0, 16'h0005, 8, -1, 99, 0, 0);
    chk(4'h8, 1, 4'h0, 16'h0005);
    `CHK(n_store - store_base, 5)
    frame(1, 0, 1, 16'h00ff, 5, -1, 2, 0, 0);
    chk(4'h8, 1, 4'h0, 16'h0002);
    `CHK(mark, 1'b1)
    i_rxr_host_model.load(2'h2, 32'h0);
    frame(1, 0, 1, 16'h00ff, 5, -1, 2, 0, 0);
    chk(4'h8, 0, 4'h8, 16'h0002);
    `CHK(ret, 1'b1)
    i_rxr_host_model.load(2'h2, 32'h6);
    frame(1, 0, 0, 16'h00ff, 6, 3, 99, 1, 0);
    chk(4'h6, 1, 4'h0, 16'h0003);
    frame(1, 0, 0, 16'h00ff, 4, -1, 99, 1, 0);
    chk(4'h2, 1, 4'h0, 16'h0004);
    `CHK(skip, 1'b0)
    `CHK(n_store - store_base, 4)
    $display("test raw done");
  endtask

  // waits a bounded time for a queue entry
  task automatic evt_wait(input logic exp_wr, input logic [5:0] code, input logic exp_irq);
    int i;
    for (i = 0; i < 4 && iq_wr !== 1'b1; i++)
      step();
    `CHK(iq_wr, exp_wr)
    if (exp_wr)
    begin
      `CHK(iq_code, code)
      `CHK(irq, exp_irq)
    end
  endtask

  task automatic t_evt();
    i_rxr_host_model.load(2'h0, 32'h8);
    evt = 32'h8;
    step();
    evt = 32'h0;
    evt_wait(1, 6'h03, 1);
    step();
    evt = 32'h20;
    step();
    evt = 32'h0;
    evt_wait(0, 6'h00, 0);
    poll = 1'b1;
    bus_err = 1'b1;
    step();
    bus_err = 1'b0;
    evt_wait(1, IQ_BUS_ERR, 0);
    iq_ovf = 1'b1;
    step();
    iq_ovf = 1'b0;
    evt_wait(1, IQ_Q_OVF, 0);
    $display("test events done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {start, save, proto, multi, rx_byte, full, pool_e, fend, ab, crc, bus_err, iq_ovf, poll} = 13'h0;
    evt = 32'h0;
    n201 = 16'h0000;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_cfg();
    t_proto();
    t_sizes();
    t_raw();
    t_evt();
    finish_test();
  end
endmodule // rxr_retain_test

// file: design/rxr_keep_decide.sv
/*
 Keep or drop decision for a finished frame from its faults and effective keep mask.
 Assumes the mask is already forced to zero when the link may not save errors.
*/
`timescale 1ns/10ps
module rxr_keep_decide
  import rxr_pkg::*;
(
  rxr_keep_if.dec kif
);

  wire [3:0] hit;
  wire clean;

  // faults whose keep bit is set
  assign hit = kif.faults & kif.mask;
  assign clean = (kif.faults == 4'h0);

  assign kif.cause = rxr_prio(hit);

  assign kif.keep = clean || (hit != 4'h0);

endmodule // rxr_keep_decide

// file: design/rxr_keep_if.sv
/*
 Carrier between the frame tracker and the keep decision.
 Assumes both ends sit on the same clock; the decision is combinational.
*/
`timescale 1ns/10ps
interface rxr_keep_if;
  logic [3:0] faults;
  logic [3:0] mask;
  logic keep;
  logic [3:0] cause;

  modport src (output faults, output mask, input keep, input cause);
  modport dec (input faults, input mask, output keep, output cause);
endinterface

// file: design/rxr_pkg.sv
/*
 Constants, types and helper functions for the receive fault retention block.
 Assumes a single 50 MHz clock and configuration words loaded by the global config block reader.
*/
// Function
// - event mask bits 31,28,15 always zero
// - protocol keep mask needs save flag, protocol
// - fault priority overrun, abort, crc, oversize
// - kept fault frame leaves counters alone
// - dropped fault frame decrements matching counters
// - every fault reported in descriptor error code
// - protocol oversize keeps even N201 bytes
// - protocol overrun keep, length before overrun
// - protocol abort keep skips residual word
// - crc keep bit retains bad crc frames
// - nonprotocol abort keep stores the whole frame
// - raw keep mask needs save flag, nonprotocol
// - raw single buffer oversize truncates to N201
// - chained pool empty keep marks descriptors
// - chained pool empty drop returns buffers
// - raw overrun keep, length before overrun
// - masked events queue entry, irq unless polling
// - overrun is byte written into full fifo
package rxr_pkg;

  // configuration word selectors on the load port
  localparam logic [1:0] SEL_EVT_MASK = 2'h0;
  localparam logic [1:0] SEL_PROTO_KEEP = 2'h1;
  localparam logic [1:0] SEL_RAW_KEEP = 2'h2;

  // reset values
  localparam logic [31:0] EVT_MASK_RESET = 32'h0000_0000;
  localparam logic [15:0] KEEP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // event mask bits that are hard zero
  localparam logic [31:0] EVT_FIXED_ZERO = 32'h9000_8000;

  // keep mask bit positions (also error code bit positions)
  localparam int KB_CRC = 0;
  localparam int KB_ABORT = 1;
  localparam int KB_OVERRUN = 2;
  localparam int KB_OVERSIZE = 3;

  // interrupt queue codes for the unmaskable events
  localparam logic [5:0] IQ_BUS_ERR = 6'h20;
  localparam logic [5:0] IQ_Q_OVF = 6'h21;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DONE} rxr_state_type;

  // first fault in evaluation order, one-hot
  function automatic logic [3:0] rxr_prio(input logic [3:0] v);
    if (v[KB_OVERRUN])
      return 4'h4;
    else if (v[KB_ABORT])
      return 4'h2;
    else if (v[KB_CRC])
      return 4'h1;
    else if (v[KB_OVERSIZE])
      return 4'h8;
    else
      return 4'h0;
  endfunction

  // index of lowest pending event
  function automatic logic [5:0] rxr_first_set(input logic [33:0] v);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = 33; i >= 0; i--)
      if (v[i])
        idx = 6'(i);
    return idx;
  endfunction

endpackage

// file: design/rxr_retain.sv
/*
 Receive fault retention: tracks a frame's bytes and faults, decides keep or drop, and
 queues masked interrupt events.
 Assumes the receive engine, DMA and config reader share I_MCLK, so no synchronisers.
*/
`timescale 1ns/10ps
module rxr_retain
  import rxr_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_CFG_WR,
  input wire logic [1:0] I_CFG_SEL,
  input wire logic [31:0] I_CFG_DATA,
  input wire logic I_FRM_START,
  input wire logic I_LINK_SAVE,
  input wire logic I_LINK_PROTO,
  input wire logic I_MULTIBUF,
  input wire logic [15:0] I_N201,
  input wire logic I_RX_BYTE,
  input wire logic I_FIFO_FULL,
  input wire logic I_POOL_EMPTY,
  input wire logic I_FRM_END,
  input wire logic I_ABORT,
  input wire logic I_CRC_BAD,
  input wire logic [31:0] I_EVT,
  input wire logic I_BUS_ERR,
  input wire logic I_IQ_OVF,
  input wire logic I_POLL_ONLY,
  input wire logic I_IRQ_ACK,
  output logic O_BYTE_STORE,
  output logic O_FRM_DONE,
  output logic O_KEEP,
  output logic [3:0] O_KEEP_CAUSE,
  output logic [3:0] O_ERR_CODE,
  output logic [15:0] O_DATA_LEN,
  output logic O_SKIP_LAST_WORD,
  output logic O_MARK_OVERSIZE,
  output logic O_RETURN_BUFS,
  output logic [3:0] O_CNT_DEC,
  output logic O_IQ_WR,
  output logic [5:0] O_IQ_CODE,
  output logic O_IRQ,
  output logic [31:0] O_EVT_MASK,
  output logic [15:0] O_PROTO_KEEP,
  output logic [15:0] O_RAW_KEEP
);

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////////////////
  // configuration words

  logic [31:0] evt_mask;
  logic [15:0] proto_keep;
  logic [15:0] raw_keep;
  wire cfg_evt;
  wire cfg_proto;
  wire cfg_raw;

  // load port decode
  assign cfg_evt = I_CFG_WR && (I_CFG_SEL == SEL_EVT_MASK);
  assign cfg_proto = I_CFG_WR && (I_CFG_SEL == SEL_PROTO_KEEP);
  assign cfg_raw = I_CFG_WR && (I_CFG_SEL == SEL_RAW_KEEP);

  // fixed zero event bits
  // keep words stored whole; upper bits are never looked at
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      evt_mask <= EVT_MASK_RESET;
      proto_keep <= KEEP_RESET;
      raw_keep <= KEEP_RESET;
    end
    else
    begin
      if (cfg_evt)
        evt_mask <= I_CFG_DATA & ~EVT_FIXED_ZERO;
      if (cfg_proto)
        proto_keep <= I_CFG_DATA[15:0];
      if (cfg_raw)
        raw_keep <= I_CFG_DATA[15:0];
    end
  end

  assign O_EVT_MASK = evt_mask;
  assign O_PROTO_KEEP = proto_keep;
  assign O_RAW_KEEP = raw_keep;
  a_evt_mask_load: assert property (cfg_evt |=> O_EVT_MASK == ($past(I_CFG_DATA) & ~EVT_FIXED_ZERO))
    else $error("event mask load wrong");

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking

  rxr_state_type state;
  rxr_state_type next_state;
  logic f_save;
  logic f_proto;
  logic f_multi;
  logic [15:0] n201;
  logic [15:0] rx_cnt;
  logic [15:0] len;
  logic [3:0] faults;
  wire in_frame;
  wire frame_end;
  wire chained;
  wire byte_ovr;
  wire over_len;
  wire over_pool;
  wire byte_ok;
  wire [3:0] next_faults;
  wire [3:0] end_faults;

  assign in_frame = (state == ST_RECV);
  assign frame_end = in_frame && I_FRM_END;
  assign chained = !f_proto && f_multi;
  assign byte_ovr = in_frame && I_RX_BYTE && I_FIFO_FULL;
  assign over_len = in_frame && I_RX_BYTE && !chained && (rx_cnt >= n201);
  assign over_pool = in_frame && I_RX_BYTE && chained && I_POOL_EMPTY;
  // a byte goes to memory unless the fifo is full or an overrun or oversize has hit the frame
  assign byte_ok = in_frame && I_RX_BYTE && !I_FIFO_FULL && !faults[KB_OVERRUN]
                   && !faults[KB_OVERSIZE] && !over_len && !over_pool;
  assign next_faults = faults | {over_len || over_pool, byte_ovr, 2'b00};
  assign end_faults = next_faults | {2'b00, I_ABORT, I_CRC_BAD};

  // state sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (I_FRM_START)
          next_state = ST_RECV;
      ST_RECV:
        if (I_FRM_END)
          next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // link attributes caught at frame start
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      f_save <= 1'b0;
      f_proto <= 1'b0;
      f_multi <= 1'b0;
      n201 <= CNT_RESET;
    end
    else if (state == ST_IDLE && I_FRM_START)
    begin
      f_save <= I_LINK_SAVE;
      f_proto <= I_LINK_PROTO;
      f_multi <= I_MULTIBUF;
      n201 <= I_N201;
    end
  end

  // byte counts and gathered faults; rx_cnt saturates rather than wrap, len does not
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rx_cnt <= CNT_RESET;
      len <= CNT_RESET;
      faults <= 4'h0;
    end
    else if (state == ST_IDLE)
    begin
      rx_cnt <= CNT_RESET;
      len <= CNT_RESET;
      faults <= 4'h0;
    end
    else if (in_frame)
    begin
      if (I_RX_BYTE && rx_cnt != CNT_MAX)
        rx_cnt <= rx_cnt + 16'h0001;
      if (byte_ok)
        len <= len + 16'h0001;
      faults <= next_faults;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_BYTE_STORE <= 1'b0;
    else
      O_BYTE_STORE <= byte_ok;
  end

  // named steps of an overrun followed by more bytes
  sequence s_overrun;
    byte_ovr && !I_FRM_END;
  endsequence
  sequence s_later_byte;
    in_frame && I_RX_BYTE;
  endsequence
  a_ovr_no_store: assert property (s_overrun ##1 s_later_byte |=> !O_BYTE_STORE)
    else $error("byte stored after overrun");
  a_ovr_detect: assert property (s_overrun |=> faults[KB_OVERRUN])
    else $error("overrun not recorded");
  a_raw_ovr_stop: assert property (s_overrun ##1 s_later_byte ##0 !f_proto |=> !O_BYTE_STORE)
    else $error("raw link stored after overrun");
  a_single_trunc: assert property (over_len |=> !O_BYTE_STORE)
    else $error("byte stored past N201");

  ////////////////////////////////////////////////////////////////////////////
  // keep decision

  rxr_keep_if kif ();
  wire [3:0] sel_mask;
  wire [3:0] eff_mask;
  wire [15:0] end_len;

  // only the low four keep bits act
  assign sel_mask = f_proto ? proto_keep[3:0] : raw_keep[3:0];
  assign eff_mask = f_save ? sel_mask : 4'h0;
  assign kif.faults = end_faults;
  assign kif.mask = eff_mask;
  rxr_keep_decide u_decide (
    .kif(kif)
  );
  // odd N201 loses its last byte
  assign end_len = (f_proto && end_faults[KB_OVERSIZE]) ? {len[15:1], 1'b0} : len;

  // frame result, one pulse per frame end
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_FRM_DONE <= 1'b0;
      O_KEEP <= 1'b0;
      O_KEEP_CAUSE <= 4'h0;
      O_ERR_CODE <= 4'h0;
      O_DATA_LEN <= CNT_RESET;
      O_SKIP_LAST_WORD <= 1'b0;
      O_MARK_OVERSIZE <= 1'b0;
      O_RETURN_BUFS <= 1'b0;
      O_CNT_DEC <= 4'h0;
    end
    else
    begin
      O_FRM_DONE <= frame_end;
      O_ERR_CODE <= frame_end ? end_faults : 4'h0;
      O_KEEP <= frame_end && kif.keep;
      O_KEEP_CAUSE <= frame_end ? kif.cause : 4'h0;
      O_DATA_LEN <= frame_end ? end_len : O_DATA_LEN;
      O_SKIP_LAST_WORD <= frame_end && kif.keep && f_proto && end_faults[KB_ABORT];
      O_MARK_OVERSIZE <= frame_end && kif.keep && chained && end_faults[KB_OVERSIZE];
      // partial frame buffers back to pool
      O_RETURN_BUFS <= frame_end && !kif.keep && chained && end_faults[KB_OVERSIZE];
      O_CNT_DEC <= (frame_end && !kif.keep) ? end_faults : 4'h0;
    end
  end

  a_proto_mask: assert property (frame_end && f_save && f_proto && |(end_faults & proto_keep[3:0]) |=> O_KEEP)
    else $error("protocol keep mask ignored");
  a_raw_mask: assert property (frame_end && f_save && !f_proto && |(end_faults & raw_keep[3:0]) |=> O_KEEP)
    else $error("raw keep mask ignored");
  a_keep_no_dec: assert property (frame_end && |(end_faults & eff_mask) |=> O_KEEP && O_CNT_DEC == 4'h0)
    else $error("kept frame decremented a counter");
  a_drop_dec: assert property (frame_end && |end_faults && !(|(end_faults & eff_mask))
                               |=> !O_KEEP && O_CNT_DEC == $past(end_faults))
    else $error("dropped frame counters wrong");
  a_err_code: assert property (frame_end |=> O_FRM_DONE && O_ERR_CODE == $past(end_faults))
    else $error("error code mismatch");
  a_even_len: assert property (frame_end && f_proto && end_faults[KB_OVERSIZE] |=> !O_DATA_LEN[0])
    else $error("protocol oversize length odd");
  a_skip_word: assert property (frame_end && f_proto && f_save && proto_keep[KB_ABORT] && end_faults[KB_ABORT]
                                |=> O_SKIP_LAST_WORD)
    else $error("residual word not withheld");
  a_crc_drop: assert property (frame_end && end_faults == 4'h1 && !eff_mask[KB_CRC] |=> !O_KEEP)
    else $error("bad crc frame kept");
  a_cause_order: assert property (frame_end && end_faults[KB_OVERRUN] && eff_mask[KB_OVERRUN]
                                  |=> O_KEEP_CAUSE == 4'h4)
    else $error("overrun not evaluated first");
  a_pool_mark: assert property (frame_end && chained && f_save && raw_keep[KB_OVERSIZE]
                                && end_faults[KB_OVERSIZE] |=> O_MARK_OVERSIZE)
    else $error("oversize mark missing");
  a_pool_return: assert property (frame_end && chained && end_faults[KB_OVERSIZE]
                                  && !(|(end_faults & eff_mask)) |=> O_RETURN_BUFS)
    else $error("buffers not returned");
  a_no_save_drop: assert property (frame_end && !f_save && |end_faults |=> !O_KEEP)
    else $error("frame kept without save flag");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt event queue

  logic [33:0] pend;
  wire [33:0] evt_in;
  wire [33:0] clr;
  wire [33:0] next_pend;
  wire pend_nz;
  wire [5:0] pick;

  // bus error and queue overflow bypass the mask
  assign evt_in = {I_IQ_OVF, I_BUS_ERR, I_EVT & evt_mask};
  assign pend_nz = |pend;
  assign pick = rxr_first_set(pend);
  assign clr = pend_nz ? (34'h1 << pick) : 34'h0;
  // a new event wins over the clear of its own bit
  assign next_pend = (pend & ~clr) | evt_in;
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      pend <= 34'h0;
    else
      pend <= next_pend;
  end

  // one queue entry per cycle, lowest index first
  // entry plus request unless polling
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_IQ_WR <= 1'b0;
      O_IQ_CODE <= 6'h00;
      O_IRQ <= 1'b0;
    end
    else
    begin
      O_IQ_WR <= pend_nz;
      O_IQ_CODE <= pend_nz ? pick : O_IQ_CODE;
      if (pend_nz && !I_POLL_ONLY)
        O_IRQ <= 1'b1;
      else if (I_IRQ_ACK)
        O_IRQ <= 1'b0;
    end
  end

  a_iq_entry: assert property (pend_nz |=> O_IQ_WR && O_IQ_CODE == $past(pick))
    else $error("pending event not queued");
  a_irq_raise: assert property (pend_nz && !I_POLL_ONLY |=> O_IRQ)
    else $error("interrupt request not raised");
  a_masked_quiet: assert property (!pend_nz && (I_EVT & evt_mask) == 32'h0 && !I_BUS_ERR && !I_IQ_OVF
                                   |=> !pend_nz ##1 !O_IQ_WR)
    else $error("queue entry without event");

endmodule // rxr_retain
